/* rtl/gpio_port.v */
// six pin port with direction latches and internal serial memory lines
`timescale 1ns/10ps
`include "gpio_port_consts.vh"
module gpio_port #(
    parameter PINS       = `PIN_COUNT,
    parameter HAS_MEMORY = 1
) (
    input  wire            clock_in,
    input  wire            reset_n_in,
    input  wire [4:0]      file_addr_in,
    input  wire            file_read_in,
    input  wire            file_write_in,
    input  wire [7:0]      file_wdata_in,
    output reg  [7:0]      file_rdata_out,
    input  wire            dir_load_in,
    input  wire [2:0]      dir_operand_in,
    input  wire [7:0]      working_in,
    input  wire            timer_clock_source_select_in,
    input  wire            weak_pullup_enable_n_in,
    input  wire            wake_on_change_enable_n_in,
    input  wire            master_clear_input_enable_in,
    input  wire [PINS-1:0] alt_function_in,
    input  wire [PINS-1:0] pin_in,
    output wire [PINS-1:0] pin_out,
    output wire [PINS-1:0] pin_oe_out,
    output wire [PINS-1:0] pullup_enable_out,
    output wire            wake_on_change_out
);
    reg  [PINS-1:0] out_latch;
    reg             sda_latch;
    reg             scl_latch;
    reg  [PINS-1:0] wake_ref;
    wire [PINS-1:0] direction;
    wire [PINS-1:0] drive;
    wire [PINS-1:0] shared_pins;
    wire            mem_pull_low;
    wire            sda_line;
    wire            scl_line;
    wire [7:0]      port_view;
    wire            port_hit;

    assign port_hit = (file_addr_in == `PORT_ADDR);

    port_direction #(.PINS(PINS)) u_dir (
        .clock_in      (clock_in),
        .reset_n_in    (reset_n_in),
        .load_in       (dir_load_in && dir_operand_in == `DIR_LOAD_OPERAND),
        .working_in    (working_in[PINS-1:0]),
        .direction_out (direction)
    );

    // a pin drives only when its own bit is zero and no override applies
    function [PINS-1:0] drive_mask;
        input [PINS-1:0] dir;
        input            tsel;
        begin
            drive_mask                 = ~dir;
            drive_mask[`BIT_INPUT_ONLY] = 1'b0;
            if (tsel)
                drive_mask[`BIT_TIMER_PIN] = 1'b0;
        end
    endfunction

    assign drive      = drive_mask(direction, timer_clock_source_select_in);
    assign pin_oe_out = drive;
    assign pin_out    = out_latch & drive;

    // pull-up and wake are shared by the same three pins
    assign shared_pins = ({{(PINS-1){1'b0}}, 1'b1} << `BIT_PIN0)
                       | ({{(PINS-1){1'b0}}, 1'b1} << `BIT_PIN1)
                       | ({{(PINS-1){1'b0}}, 1'b1} << `BIT_INPUT_ONLY);

    // an output-driving pin has its pull-up switched off
    function [PINS-1:0] pullup_mask;
        input [PINS-1:0] shared;
        input [PINS-1:0] drv;
        input            pu_n;
        input            master_clear_input;
        begin
            pullup_mask = shared & ~drv & {PINS{~pu_n}};
            if (master_clear_input)
                pullup_mask[`BIT_INPUT_ONLY] = 1'b1;
        end
    endfunction

    assign pullup_enable_out = pullup_mask(shared_pins, drive, weak_pullup_enable_n_in, master_clear_input_enable_in);

    // wake compares current pin levels to those seen at the last port read
    wire [PINS-1:0] wake_pins = shared_pins & ~drive & ~alt_function_in
                              & ~({{(PINS-1){1'b0}}, master_clear_input_enable_in} << `BIT_INPUT_ONLY);
    assign wake_on_change_out = ~wake_on_change_enable_n_in
                              & |((pin_in ^ wake_ref) & wake_pins);

    // serial data is wired-and of our open-drain and the memory; the latch resets high, so it idles high
    assign sda_line = sda_latch & ~(HAS_MEMORY != 0 && mem_pull_low);
    assign scl_line = scl_latch;

    generate
        if (HAS_MEMORY != 0)
        begin : g_mem
            serial_memory u_mem (
                .clock_in         (clock_in),
                .reset_n_in       (reset_n_in),
                .scl_in           (scl_line),
                .sda_in           (sda_line),
                .sda_pull_low_out (mem_pull_low)
            );
        end
        else
        begin : g_nomem
            assign mem_pull_low = 1'b0;
        end
    endgenerate

    // pin levels sampled at read time, alternate functions masked
    assign port_view[PINS-1:0] = pin_in & ~alt_function_in;
    assign port_view[`BIT_SDA] = (HAS_MEMORY != 0) ? sda_line : 1'b0;
    assign port_view[`BIT_SCL] = (HAS_MEMORY != 0) ? scl_line : 1'b0;

    always @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            file_rdata_out <= 8'h00;
            wake_ref       <= {PINS{1'b0}};
        end
        else
        begin
            if (file_read_in && port_hit)
            begin
                file_rdata_out <= port_view;
                wake_ref       <= pin_in;
            end
            else
                file_rdata_out <= 8'h00;
        end
    end

    // output latches hold until rewritten; core writes back its pin-based operand
    always @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            out_latch <= {PINS{1'b0}};
            sda_latch <= `SERIAL_RESET;
            scl_latch <= `SERIAL_RESET;
        end
        else if (file_write_in && port_hit)
        begin
            out_latch <= file_wdata_in[PINS-1:0];
            sda_latch <= file_wdata_in[`BIT_SDA];
            scl_latch <= file_wdata_in[`BIT_SCL];
        end
    end
endmodule

/* rtl/gpio_port_consts.vh */
// constants for the six pin port with serial memory lines
`ifndef GPIO_PORT_CONSTS_VH
`define GPIO_PORT_CONSTS_VH
`define PORT_ADDR         5'h06
`define DIR_LOAD_OPERAND  3'h6
`define PORT_WIDTH        8
`define PIN_COUNT         6
`define DIR_RESET         6'h3f
`define SERIAL_RESET      1'b1
`define BIT_SDA           6
`define BIT_SCL           7
`define BIT_PIN0          0
`define BIT_PIN1          1
`define BIT_TIMER_PIN     2
`define BIT_INPUT_ONLY    3
`define MEM_BYTES         16
`define MEM_ADDR_BITS     4
`define DEV_ADDR_BITS     7
`define DEV_ADDR_DEFAULT  7'h50
`endif

/* rtl/port_direction.v */
// direction latches, loaded from the working register
`timescale 1ns/10ps
`include "gpio_port_consts.vh"
module port_direction #(
    parameter PINS = `PIN_COUNT
) (
    input  wire            clock_in,
    input  wire            reset_n_in,
    input  wire            load_in,
    input  wire [PINS-1:0] working_in,
    output reg  [PINS-1:0] direction_out
);
    // write-only: no read path exists for this latch set
    always @(posedge clock_in)
    begin
        if (!reset_n_in)
            direction_out <= `DIR_RESET;
        else if (load_in)
            direction_out <= working_in;
    end
endmodule

/* rtl/serial_memory.v */
// sixteen byte two-wire serial memory fed by the port serial lines
`timescale 1ns/10ps
`include "gpio_port_consts.vh"
module serial_memory #(
    parameter BYTES = `MEM_BYTES,
    parameter ABITS = `MEM_ADDR_BITS,
    parameter [`DEV_ADDR_BITS-1:0] DEV_ADDR = `DEV_ADDR_DEFAULT
) (
    input  wire clock_in,
    input  wire reset_n_in,
    input  wire scl_in,
    input  wire sda_in,
    output reg  sda_pull_low_out
);
    localparam ST_IDLE = 5'b00001;
    localparam ST_DEV  = 5'b00010;
    localparam ST_ADDR = 5'b00100;
    localparam ST_WR   = 5'b01000;
    localparam ST_RD   = 5'b10000;
    reg [7:0]       mem [0:BYTES-1];
    reg [4:0]       state;
    reg [4:0]       next_state;
    reg [7:0]       shift;
    reg [3:0]       count;
    reg [ABITS-1:0] ptr;
    reg             scl_q;
    reg             sda_q;
    reg             ack_phase;
    reg             reading;
    wire scl_rise = scl_in & ~scl_q;
    wire scl_fall = ~scl_in & scl_q;
    wire start    = scl_in & scl_q & sda_q & ~sda_in;
    wire stop     = scl_in & scl_q & ~sda_q & sda_in;
    wire byte_done = (count == 4'h8);
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE: next_state = ST_IDLE;
            ST_DEV:  if (byte_done && scl_fall)
                         next_state = (shift[7:1] != DEV_ADDR) ? ST_IDLE : (shift[0] ? ST_RD : ST_ADDR);
            ST_ADDR: if (byte_done && scl_fall)
                         next_state = ST_WR;
            ST_WR:   next_state = ST_WR;
            ST_RD:   next_state = ST_RD;
            default: next_state = ST_IDLE;
        endcase
        if (start)
            next_state = ST_DEV;
        else if (stop)
            next_state = ST_IDLE;
    end
    always @(posedge clock_in)
    begin
        if (!reset_n_in)
        begin
            state            <= ST_IDLE;
            shift            <= 8'h00;
            count            <= 4'h0;
            ptr              <= {ABITS{1'b0}};
            scl_q            <= 1'b1;
            sda_q            <= 1'b1;
            ack_phase        <= 1'b0;
            reading          <= 1'b0;
            sda_pull_low_out <= 1'b0;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            state <= next_state;
            if (start || stop)
            begin
                count            <= 4'h0;
                ack_phase        <= 1'b0;
                reading          <= 1'b0;
                sda_pull_low_out <= 1'b0;
            end
            else if (scl_rise && !ack_phase)
            begin
                shift <= {shift[6:0], sda_in};
                count <= count + 4'h1;
            end
            else if (scl_fall)
            begin
                if (ack_phase)
                begin
                    ack_phase <= 1'b0;
                    count     <= 4'h0;
                    // read: present next byte msb first, unless master did not ack
                    if (reading && !sda_in)
                    begin
                        shift            <= mem[ptr];
                        ptr              <= ptr + 1'b1;
                        sda_pull_low_out <= ~mem[ptr][7];
                        count            <= 4'h1;
                    end
                    else
                        sda_pull_low_out <= 1'b0;
                end
                else if (state == ST_RD && reading && !byte_done)
                begin
                    sda_pull_low_out <= ~shift[7-count[2:0]];
                    count            <= count + 4'h1;
                end
                else if (byte_done)
                begin
                    ack_phase <= 1'b1;
                    if (state == ST_RD)
                        sda_pull_low_out <= 1'b0;
                    else if (state == ST_DEV && shift[7:1] == DEV_ADDR)
                    begin
                        sda_pull_low_out <= 1'b1;
                        reading          <= shift[0];
                        if (shift[0])
                        begin
                            shift <= mem[ptr];
                            ptr   <= ptr + 1'b1;
                        end
                    end
                    else if (state == ST_ADDR)
                    begin
                        ptr              <= shift[ABITS-1:0];
                        sda_pull_low_out <= 1'b1;
                    end
                    else if (state == ST_WR)
                    begin
                        mem[ptr]         <= shift;
                        ptr              <= ptr + 1'b1;
                        sda_pull_low_out <= 1'b1;
                    end
                end
            end
            else if (ack_phase && reading && scl_rise)
                sda_pull_low_out <= 1'b0;
            if (ack_phase && reading && state == ST_RD && scl_fall && sda_pull_low_out == 1'b0 && count == 4'h8)
                sda_pull_low_out <= ~shift[7];
        end
    end
endmodule

/* verification/gpio_port_bench.sv */
// self-checking bench for the six pin port
`timescale 1ns/10ps
module gpio_port_bench;
    reg        clock_in = 0;
    reg        reset_n_in = 0;
    reg  [4:0] addr = 0;
    reg        rd_s = 0, wr_s = 0, ld_s = 0, tsel = 0, pu_n = 1, wk_n = 1, master_clear_input = 0;
    reg  [7:0] wdata = 0, work = 0, rdv;
    reg  [2:0] oper = 0;
    reg  [5:0] alt = 0, ext_en = 6'h3f, ext_val = 0, d, w, e, o;
    reg  [31:0] rows [0:3];
    wire [7:0] rdata;
    wire [5:0] pin_in, pin_out, pin_oe, pull;
    wire       wake;
    integer    error_cnt = 0, checks = 0, i;
    reg  [7:0] r;
    gpio_port dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in), .file_addr_in(addr), .file_read_in(rd_s),
        .file_write_in(wr_s), .file_wdata_in(wdata), .file_rdata_out(rdata), .dir_load_in(ld_s),
        .dir_operand_in(oper), .working_in(work), .timer_clock_source_select_in(tsel),
        .weak_pullup_enable_n_in(pu_n), .wake_on_change_enable_n_in(wk_n),
        .master_clear_input_enable_in(master_clear_input), .alt_function_in(alt), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_out(pin_oe), .pullup_enable_out(pull), .wake_on_change_out(wake));
    pin_model pins_u (.clock_in(clock_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe), .pullup_in(pull),
        .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_in));
    initial
    begin
        forever #25 clock_in = ~clock_in;
    end
    task cmp(input [8*10:1] nm, input [7:0] seen, input [7:0] exp);
    begin
        checks = checks + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("mismatch %0s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    // kind 0 read, 1 write, 2 direction load; strobe held over one rising edge
    task op(input [1:0] kind, input [4:0] a, input [7:0] v);
    begin
        addr = a;
        oper = a[2:0];
        wdata = v;
        work = v;
        rd_s = (kind == 2'd0);
        wr_s = (kind == 2'd1);
        ld_s = (kind == 2'd2);
        @(negedge clock_in);
        rd_s = 0;
        wr_s = 0;
        ld_s = 0;
        rdv = rdata;
        @(negedge clock_in);
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    initial
    begin
        #(50 * 3000);
        error_cnt = error_cnt + 1;
        end_sim;
    end
    initial
    begin
        rows[0] = {6'h00, 6'h15, 6'h3f, 6'h37, 8'hdd};
        rows[1] = {6'h3f, 6'h00, 6'h2a, 6'h00, 8'hea};
        rows[2] = {6'h0f, 6'h30, 6'h05, 6'h30, 8'hf5};
        rows[3] = {6'h30, 6'h0a, 6'h15, 6'h07, 8'hd2};
        repeat (3) @(negedge clock_in);
        reset_n_in = 1;
        cmp("oe reset", {2'h0, pin_oe}, 8'h00);
        op(0, 5'h06, 8'h00);
        cmp("reset rd", rdv, 8'hc0);
        for (i = 0; i < 4; i = i + 1)
        begin
            {d, w, e, o, r} = rows[i];
            op(2, 5'h06, {2'h0, d});
            op(1, 5'h06, {2'h3, w});
            ext_val = e;
            op(0, 5'h06, 8'h00);
            cmp("port rd", rdv, r);
            cmp("oe", {2'h0, pin_oe}, {2'h0, o});
        end
        op(2, 5'h05, 8'h00);
        cmp("bad oper", {2'h0, pin_oe}, 8'h07);
        op(2, 5'h06, 8'h00);
        tsel = 1;
        #1 cmp("timer pin", {2'h0, pin_oe}, 8'h33);
        tsel = 0;
        op(1, 5'h07, 8'h00);
        op(0, 5'h07, 8'h00);
        cmp("unmapped", rdv, 8'h00);
        op(0, 5'h06, 8'h00);
        cmp("latch", rdv, 8'hc2);
        op(2, 5'h06, 8'h3f);
        op(1, 5'h06, 8'hff);
        ext_val = 6'h00;
        op(0, 5'h06, 8'h00);
        op(1, 5'h06, rdv);
        op(2, 5'h06, 8'h00);
        cmp("rmw", {2'h0, pin_out}, 8'h00);
        op(2, 5'h06, 8'h3f);
        ext_en = 6'h00;
        pu_n = 0;
        #1 cmp("pullups", {2'h0, pull}, 8'h0b);
        op(0, 5'h06, 8'h00);
        cmp("pulled", rdv & 8'hcb, 8'hcb);
        pu_n = 1;
        master_clear_input = 1;
        #1 cmp("master_clear_input pu", {2'h0, pull}, 8'h08);
        master_clear_input = 0;
        ext_en = 6'h3f;
        ext_val = 6'h3f;
        alt = 6'h01;
        op(0, 5'h06, 8'h00);
        cmp("alt rd", rdv, 8'hfe);
        alt = 0;
        // last port read saw all pins high, so only a later change may wake
        wk_n = 0;
        #1 cmp("wake idle", {7'h00, wake}, 8'h00);
        ext_val = 6'h3e;
        #1 cmp("wake pin0", {7'h00, wake}, 8'h01);
        master_clear_input = 1;
        ext_val = 6'h37;
        #1 cmp("wake master_clear_input", {7'h00, wake}, 8'h00);
        master_clear_input = 0;
        wk_n = 1;
        ext_val = 6'h3f;
        // clock dropped with data held high, so no start or stop is seen
        op(1, 5'h06, 8'h40);
        op(0, 5'h06, 8'h00);
        cmp("serial rd", rdv, 8'h7f);
        op(1, 5'h06, 8'hc0);
        end_sim;
    end
endmodule

/* verification/gpio_port_properties.sv */
// assertion checker watching the port pins and register reads
`timescale 1ns/10ps
module gpio_port_properties #(
    parameter PINS = 6
) (
    input wire            clock_in,
    input wire            reset_n_in,
    input wire [4:0]      file_addr_in,
    input wire            file_read_in,
    input wire            file_write_in,
    input wire [7:0]      file_wdata_in,
    input wire [7:0]      file_rdata_out,
    input wire            dir_load_in,
    input wire [2:0]      dir_operand_in,
    input wire [7:0]      working_in,
    input wire            timer_clock_source_select_in,
    input wire            weak_pullup_enable_n_in,
    input wire            wake_on_change_enable_n_in,
    input wire            master_clear_input_enable_in,
    input wire [PINS-1:0] alt_function_in,
    input wire [PINS-1:0] pin_in,
    input wire [PINS-1:0] pin_out,
    input wire [PINS-1:0] pin_oe_out,
    input wire [PINS-1:0] pullup_enable_out,
    input wire            wake_on_change_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    sequence port_read_s;
        file_read_in && file_addr_in == 5'h06;
    endsequence
    sequence port_write_s;
        file_write_in && file_addr_in == 5'h06;
    endsequence
    a_reset_float: assert property ($rose(reset_n_in) |-> pin_oe_out == 0) else $error("drivers on after reset");
    a_input_only: assert property (!pin_oe_out[3]) else $error("input-only pin driven");
    a_dir_load: assert property (dir_load_in && dir_operand_in == 3'h6 |=>
        {pin_oe_out[5:4], pin_oe_out[1:0]} == ~{$past(working_in[5:4]), $past(working_in[1:0])})
        else $error("direction load wrong");
    a_operand_refused: assert property (dir_load_in && dir_operand_in != 3'h6 |=>
        $stable({pin_oe_out[5:4], pin_oe_out[1:0]})) else $error("other operand loaded direction");
    a_timer_input: assert property (timer_clock_source_select_in |-> !pin_oe_out[2])
        else $error("timer pin driven");
    a_read_live: assert property (port_read_s |=> file_rdata_out[PINS-1:0] == $past(pin_in & ~alt_function_in))
        else $error("port read not pin levels");
    a_read_other: assert property (file_read_in && file_addr_in != 5'h06 |=> file_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_write_latch: assert property (port_write_s |=> pin_out == ($past(file_wdata_in[PINS-1:0]) & pin_oe_out))
        else $error("output latch wrong");
    a_pullup_pins: assert property (pullup_enable_out[5:4] == 2'b00 && !pullup_enable_out[2])
        else $error("pull-up on unsupported pin");
    a_master_clear_input_pullup: assert property (master_clear_input_enable_in |-> pullup_enable_out[3])
        else $error("master clear pull-up off");
endmodule
bind gpio_port gpio_port_properties #(.PINS(PINS)) props_u (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .file_addr_in(file_addr_in), .file_read_in(file_read_in), .file_write_in(file_write_in),
    .file_wdata_in(file_wdata_in), .file_rdata_out(file_rdata_out), .dir_load_in(dir_load_in),
    .dir_operand_in(dir_operand_in), .working_in(working_in),
    .timer_clock_source_select_in(timer_clock_source_select_in),
    .weak_pullup_enable_n_in(weak_pullup_enable_n_in), .wake_on_change_enable_n_in(wake_on_change_enable_n_in),
    .master_clear_input_enable_in(master_clear_input_enable_in), .alt_function_in(alt_function_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .pullup_enable_out(pullup_enable_out),
    .wake_on_change_out(wake_on_change_out));

/* verification/pin_model.sv */
// outside world of the port pins: drivers, pull-ups and external sources
`timescale 1ns/10ps
module pin_model (
    input  wire       clock_in,
    input  wire [5:0] pin_out_in,
    input  wire [5:0] pin_oe_in,
    input  wire [5:0] pullup_in,
    input  wire [5:0] ext_en_in,
    input  wire [5:0] ext_val_in,
    output wire [5:0] level_out
);
    reg [5:0] drift = 6'h15;
    // a floating pin wanders so it never passes for a held level
    always @(posedge clock_in)
        drift <= ~drift;
    assign level_out = (pin_oe_in & pin_out_in)
                     | (~pin_oe_in & ext_en_in & ext_val_in)
                     | (~pin_oe_in & ~ext_en_in & (pullup_in | drift));
endmodule
